// ===== src/cirq_entry_unit.sv
// interrupt entry, ranking and real-time context stack
//
// Behaviour
// - on critical or real-time entry, save full context within 8 cycles.
// - real-time return restores saved context within 8 cycles.
// - real-time nesting stops one level short; last kept for critical.
// - depth ptr increments on critical/real-time entry, decrements on return.
// - warning raised while depth ptr is at or above warn level.
// - depth ptr equal to full level puts the unit in fault.
// - warn level is software written; full level fixed by hardware.
// - rank reset, critical, real-time, low-priority; serve highest.
// - active-low reset resets internally; cannot be aborted or nested.
// - reset aborts and flushes all pipeline operations.
// - reset zeroes registers except warn level (6); main status loads 0x07F8_0000.
// - critical line has no enable, mask or block.
// - critical request preempts handlers even inside uninterruptible_section_op sections.
// - critical input latched internally until serviced.
// - first critical/real-time handler packet must be paired entry ops, else fault.
// - entry op a loads A15 with secure base chosen by the current-stack field.
// - stack contents hidden; working registers zeroed on critical/real-time entry.
// - no global enable for real-time line; masking is external.
// - low-priority entry clears the low-priority enable bit.
// - low-priority request waits until current stack is its stack.
`timescale 1ns/1ps
module cirq_entry_unit #(
    parameter int STACK_DEPTH = cirq_pkg::STACK_DEPTH,
    parameter int NSTACK = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_cpu_reset_low,
    input wire logic i_critical_irq_low,
    input wire logic i_realtime_irq,
    input wire logic i_low_prio_irq,
    input wire logic i_boundary,
    input wire logic i_uninterruptible_section_op,
    input wire logic i_realtime_return_op,
    input wire logic i_first_packet_valid,
    input wire logic i_handler_entry_op_a,
    input wire logic i_handler_entry_op_b,
    input wire logic i_warn_we,
    input wire logic [cirq_pkg::PTR_W-1:0] i_warn_wdata,
    input wire logic i_lp_enable_set,
    input wire logic [2:0] i_low_prio_stack_sel,
    input wire logic [31:0] i_secure_stack_base [NSTACK],
    input wire cirq_pkg::cirq_ctx_s i_ctx,
    output logic o_pipe_flush,
    output logic o_take,
    output cirq_pkg::cirq_src_e o_take_src,
    output logic o_ctx_busy,
    output logic o_zero_working,
    output logic o_restore_valid,
    output cirq_pkg::cirq_ctx_s o_ctx,
    output logic o_a15_load,
    output logic [31:0] o_a15_value,
    output logic [31:0] o_irq_status_reg,
    output logic [31:0] o_main_status_reg,
    output logic [cirq_pkg::PTR_W-1:0] o_rt_stack_depth_ptr,
    output logic [cirq_pkg::PTR_W-1:0] o_rt_stack_warn_level,
    output logic [cirq_pkg::PTR_W-1:0] o_rt_stack_full_level,
    output cirq_pkg::cirq_err_s o_err
);
    localparam int PW = cirq_pkg::PTR_W;
    // full level is a constant: no write path exists
    localparam logic [PW-1:0] FULL_LVL = PW'(STACK_DEPTH);

    // current-stack field of the interrupt status word
    function automatic logic [cirq_pkg::CURR_SP_W-1:0] cur_stack(
        input logic [31:0] sts
    );
        return sts[cirq_pkg::CURR_SP_LSB +: cirq_pkg::CURR_SP_W];
    endfunction : cur_stack

    // ========================================================
    // input synchronisers
    logic [1:0] rst_sync;
    logic [1:0] crit_sync;
    logic [1:0] rt_sync;
    logic [1:0] lp_sync;
    logic cpu_rst;
    logic crit_req;
    logic rt_req;
    logic lp_req;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rst_sync <= 2'h0;
            crit_sync <= 2'h0;
            rt_sync <= 2'h0;
            lp_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], ~i_cpu_reset_low};
            crit_sync <= {crit_sync[0], ~i_critical_irq_low};
            rt_sync <= {rt_sync[0], i_realtime_irq};
            lp_sync <= {lp_sync[0], i_low_prio_irq};
        end
    end
    assign cpu_rst = rst_sync[1] | i_reset;
    assign rt_req = rt_sync[1];
    assign lp_req = lp_sync[1];

    // ========================================================
    // state
    cirq_pkg::cirq_state_e state;
    logic [cirq_pkg::CTX_CNT_W-1:0] cnt;
    logic [PW-1:0] depth;
    logic [PW-1:0] warn_lvl;
    logic [31:0] main_status;
    logic [31:0] irq_status;
    logic crit_pend;
    logic in_lp;
    logic entry_is_crit;
    cirq_pkg::cirq_ctx_s stack_mem [STACK_DEPTH];
    cirq_pkg::cirq_src_e pick;
    logic take_now;
    logic idle;
    logic lp_stack_ok;
    logic rt_room;

    assign idle = (state == cirq_pkg::CIRQ_IDLE);
    // real-time needs two free levels so the last one stays for critical
    assign rt_room = (depth + 4'h1) < FULL_LVL;
    assign lp_stack_ok = cur_stack(irq_status)
        == i_low_prio_stack_sel;
    assign crit_req = crit_pend;

    // ranking: reset handled by cpu_rst above everything
    always_comb begin
        pick = cirq_pkg::CIRQ_SRC_NONE;
        if (crit_req && depth < FULL_LVL) begin
            pick = cirq_pkg::CIRQ_SRC_CRIT;
        end else if (rt_req && rt_room && !i_uninterruptible_section_op) begin
            pick = cirq_pkg::CIRQ_SRC_RT;
        end else if (lp_req && main_status[cirq_pkg::LP_ENABLE_BIT]
                     && lp_stack_ok && !i_uninterruptible_section_op) begin
            pick = cirq_pkg::CIRQ_SRC_LP;
        end
    end
    // only one line taken, at a boundary; the rest stay pending
    assign take_now = idle && i_boundary
        && (pick != cirq_pkg::CIRQ_SRC_NONE);

    // ========================================================
    // critical latch: set wins over clear
    always_ff @(posedge i_sys_clk) begin
        if (cpu_rst) begin
            crit_pend <= 1'b0;
        end else if (crit_sync[1]) begin
            crit_pend <= 1'b1;
        end else if (take_now && pick == cirq_pkg::CIRQ_SRC_CRIT) begin
            crit_pend <= 1'b0;
        end
    end

    // ========================================================
    // sequencer
    always_ff @(posedge i_sys_clk) begin
        if (cpu_rst) begin
            state <= cirq_pkg::CIRQ_IDLE;
            cnt <= '0;
            entry_is_crit <= 1'b0;
        end else begin
            unique case (state)
                cirq_pkg::CIRQ_IDLE: begin
                    cnt <= '0;
                    if (take_now && pick != cirq_pkg::CIRQ_SRC_LP) begin
                        state <= cirq_pkg::CIRQ_SAVE;
                        entry_is_crit <= (pick == cirq_pkg::CIRQ_SRC_CRIT);
                    end else if (i_realtime_return_op && depth != '0) begin
                        state <= cirq_pkg::CIRQ_RESTORE;
                    end
                end
                cirq_pkg::CIRQ_SAVE: begin
                    cnt <= cnt + 3'h1;
                    if (cnt == 3'(cirq_pkg::SAVE_CYCLES - 1)) begin
                        state <= cirq_pkg::CIRQ_CHECK;
                    end
                end
                cirq_pkg::CIRQ_CHECK: begin
                    if (i_first_packet_valid) begin
                        if (i_handler_entry_op_a && i_handler_entry_op_b) begin
                            state <= cirq_pkg::CIRQ_IDLE;
                        end else begin
                            state <= cirq_pkg::CIRQ_FAULT;
                        end
                    end
                end
                cirq_pkg::CIRQ_RESTORE: begin
                    cnt <= cnt + 3'h1;
                    if (cnt == 3'(cirq_pkg::RESTORE_CYCLES - 1)) begin
                        state <= cirq_pkg::CIRQ_IDLE;
                    end
                end
                cirq_pkg::CIRQ_FAULT: begin
                    state <= cirq_pkg::CIRQ_FAULT;
                end
                default: state <= cirq_pkg::CIRQ_FAULT;
            endcase
            // a full stack is sticky: only a reset leaves the fault
            if (depth == FULL_LVL) begin
                state <= cirq_pkg::CIRQ_FAULT;
            end
        end
    end

    // ========================================================
    // depth pointer and hidden stack storage
    always_ff @(posedge i_sys_clk) begin
        if (cpu_rst) begin
            depth <= '0;
        end else if (take_now && pick != cirq_pkg::CIRQ_SRC_LP) begin
            depth <= depth + 4'h1;
        end else if (idle && i_realtime_return_op && depth != '0) begin
            depth <= depth - 4'h1;
        end
    end

    // contents have no read path except the restore port
    always_ff @(posedge i_sys_clk) begin
        if (take_now && pick != cirq_pkg::CIRQ_SRC_LP) begin
            stack_mem[depth[PW-2:0]] <= i_ctx;
        end
    end

    // ========================================================
    // warn level and status registers
    always_ff @(posedge i_sys_clk) begin
        if (cpu_rst) begin
            warn_lvl <= cirq_pkg::WARN_RESET;
        end else if (i_warn_we) begin
            warn_lvl <= i_warn_wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (cpu_rst) begin
            main_status <= cirq_pkg::MAIN_STATUS_RESET;
            irq_status <= cirq_pkg::ZERO_WORD;
        end else if (take_now && pick == cirq_pkg::CIRQ_SRC_LP) begin
            main_status[cirq_pkg::LP_ENABLE_BIT] <= 1'b0;
        end else if (i_lp_enable_set) begin
            main_status[cirq_pkg::LP_ENABLE_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (cpu_rst) begin
            in_lp <= 1'b0;
        end else begin
            in_lp <= take_now && pick == cirq_pkg::CIRQ_SRC_LP;
        end
    end

    // ========================================================
    // outputs, all registered
    always_ff @(posedge i_sys_clk) begin
        if (cpu_rst) begin
            o_pipe_flush <= 1'b1;
            o_take <= 1'b0;
            o_take_src <= cirq_pkg::CIRQ_SRC_NONE;
            o_ctx_busy <= 1'b0;
            o_zero_working <= 1'b1;
            o_restore_valid <= 1'b0;
            o_ctx <= '0;
            o_a15_load <= 1'b0;
            o_a15_value <= cirq_pkg::ZERO_WORD;
            o_err <= '0;
        end else begin
            o_pipe_flush <= 1'b0;
            o_take <= take_now;
            o_take_src <= take_now ? pick : cirq_pkg::CIRQ_SRC_NONE;
            o_ctx_busy <= !idle && state != cirq_pkg::CIRQ_FAULT;
            o_zero_working <= take_now
                && pick != cirq_pkg::CIRQ_SRC_LP;
            o_restore_valid <= state == cirq_pkg::CIRQ_RESTORE
                && cnt == 3'(cirq_pkg::RESTORE_CYCLES - 1);
            if (state == cirq_pkg::CIRQ_RESTORE) begin
                o_ctx <= stack_mem[depth[PW-2:0]];
            end
            o_a15_load <= state == cirq_pkg::CIRQ_CHECK
                && i_first_packet_valid && i_handler_entry_op_a
                && i_handler_entry_op_b;
            o_a15_value <= i_secure_stack_base[
                cur_stack(irq_status)];
            o_err.stack_warn <= depth >= warn_lvl;
            o_err.stack_full <= depth == FULL_LVL;
            o_err.entry_fault <= state == cirq_pkg::CIRQ_FAULT;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        o_irq_status_reg <= irq_status;
        o_main_status_reg <= main_status;
        o_rt_stack_depth_ptr <= depth;
        o_rt_stack_warn_level <= warn_lvl;
        o_rt_stack_full_level <= FULL_LVL;
    end
endmodule : cirq_entry_unit

// ===== src/cirq_pkg.sv
// package for the interrupt entry and real-time stack block
package cirq_pkg;
    // ========================================================
    // sizes and reset values
    localparam int STACK_DEPTH = 8;
    localparam int PTR_W = 4;
    localparam int CTX_WORDS = 8;
    localparam int CTX_CNT_W = 3;
    localparam logic [31:0] MAIN_STATUS_RESET = 32'h07f8_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [PTR_W-1:0] WARN_RESET = 4'h6;
    localparam int SAVE_CYCLES = 8;
    localparam int RESTORE_CYCLES = 8;
    localparam int LP_ENABLE_BIT = 4;
    localparam int CURR_SP_LSB = 0;
    localparam int CURR_SP_W = 3;

    // ========================================================
    // types
    typedef enum logic [4:0] {
        CIRQ_IDLE = 5'b00001,
        CIRQ_SAVE = 5'b00010,
        CIRQ_CHECK = 5'b00100,
        CIRQ_RESTORE = 5'b01000,
        CIRQ_FAULT = 5'b10000
    } cirq_state_e;

    typedef enum logic [1:0] {
        CIRQ_SRC_NONE = 2'h0,
        CIRQ_SRC_CRIT = 2'h1,
        CIRQ_SRC_RT = 2'h2,
        CIRQ_SRC_LP = 2'h3
    } cirq_src_e;

    typedef struct packed {
        logic [31:0] return_pc_reg;
        logic [31:0] main_status_reg;
        logic [31:0] ext_status_reg;
        logic [31:0] ret_addr;
    } cirq_ctx_s;

    typedef struct packed {
        logic stack_warn;
        logic stack_full;
        logic entry_fault;
    } cirq_err_s;
endpackage : cirq_pkg

// ===== verif/cirq_props.sv
// assertion checker for the interrupt entry unit
`timescale 1ns/1ps
module cirq_props (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_critical_irq_low,
    input wire logic i_uninterruptible_section_op,
    input wire logic i_realtime_return_op,
    input wire logic i_first_packet_valid,
    input wire logic i_handler_entry_op_a,
    input wire logic i_handler_entry_op_b,
    input wire logic o_pipe_flush,
    input wire logic o_take,
    input wire cirq_pkg::cirq_src_e o_take_src,
    input wire logic o_ctx_busy,
    input wire logic o_zero_working,
    input wire logic o_restore_valid,
    input wire logic o_a15_load,
    input wire logic [31:0] o_irq_status_reg,
    input wire logic [31:0] o_main_status_reg,
    input wire logic [cirq_pkg::PTR_W-1:0] o_rt_stack_depth_ptr,
    input wire logic [cirq_pkg::PTR_W-1:0] o_rt_stack_warn_level,
    input wire cirq_pkg::cirq_err_s o_err
);
    // ========================================================
    // entry, stack and packet checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    sequence s_stack_take;
        o_take && o_take_src != cirq_pkg::CIRQ_SRC_LP;
    endsequence
    sequence s_packet;
        i_first_packet_valid && o_ctx_busy;
    endsequence
    sequence s_crit_req;
        $fell(i_critical_irq_low) && !o_ctx_busy && !o_err.stack_full
            && !o_err.entry_fault;
    endsequence
    reset_release_a: assert property ($fell(i_reset) |-> o_pipe_flush
        && o_irq_status_reg == cirq_pkg::ZERO_WORD && !o_take)
        else $error("state not cleared at reset release");
    crit_latch_a: assert property (s_crit_req |-> ##[3:8]
        (o_take && o_take_src == cirq_pkg::CIRQ_SRC_CRIT))
        else $error("critical request not taken");
    take_single_a: assert property (o_take |=> !o_take)
        else $error("two takes back to back");
    entry_zero_a: assert property (s_stack_take |-> o_zero_working)
        else $error("working registers not zeroed on entry");
    rt_gate_a: assert property (o_take && o_take_src == cirq_pkg::CIRQ_SRC_RT
        |-> !$past(i_uninterruptible_section_op) && $past(o_rt_stack_depth_ptr) < 4'h7)
        else $error("real-time entry taken when blocked");
    lp_clear_a: assert property (o_take && o_take_src == cirq_pkg::CIRQ_SRC_LP
        |-> ##[1:3] !o_main_status_reg[cirq_pkg::LP_ENABLE_BIT])
        else $error("low-priority enable not cleared");
    warn_level_a: assert property ($stable(o_rt_stack_depth_ptr)
        && $stable(o_rt_stack_warn_level) |-> o_err.stack_warn
        == (o_rt_stack_depth_ptr >= o_rt_stack_warn_level))
        else $error("stack warning wrong");
    full_fault_a: assert property (o_rt_stack_depth_ptr == 4'h8
        |-> ##[0:2] o_err.stack_full)
        else $error("full stack not flagged");
    restore_time_a: assert property (i_realtime_return_op && !o_ctx_busy
        && o_rt_stack_depth_ptr != 4'h0 |-> ##[1:10] o_restore_valid)
        else $error("restore too slow");
    pkt_bad_a: assert property (s_packet ##0 !(i_handler_entry_op_a
        && i_handler_entry_op_b) |-> ##[1:2] o_err.entry_fault)
        else $error("bad entry packet not faulted");
    pkt_good_a: assert property (s_packet ##0 i_handler_entry_op_a
        && i_handler_entry_op_b |-> ##[1:2] o_a15_load)
        else $error("stack base not loaded");
endmodule : cirq_props

bind cirq_entry_unit cirq_props u_cirq_props (.*);

// ===== verif/cirq_err_agg.sv
// error aggregator model driving the critical request line
`timescale 1ns/1ps
module cirq_err_agg (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_sw_req,
    input wire cirq_pkg::cirq_err_s i_err,
    output logic o_critical_irq_low
);
    // ========================================================
    // faults reported by the cpu come back as a critical request
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_critical_irq_low <= 1'b1;
        end else begin
            o_critical_irq_low <= !(i_sw_req || i_err.stack_full
                || i_err.entry_fault);
        end
    end
endmodule : cirq_err_agg

// ===== verif/tb_top.sv
// self-checking bench for the interrupt entry unit
`timescale 1ns/1ps
module tb_top;
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_cpu_reset_low = 1'b1, i_boundary = 1'b1, i_uninterruptible_section_op = 1'b0;
    logic i_realtime_irq = 1'b0, i_low_prio_irq = 1'b0, sw_req = 1'b0;
    logic i_realtime_return_op = 1'b0, i_first_packet_valid = 1'b0;
    logic i_handler_entry_op_a = 1'b0, i_handler_entry_op_b = 1'b0;
    logic i_warn_we = 1'b0, i_lp_enable_set = 1'b0, i_critical_irq_low;
    logic [cirq_pkg::PTR_W-1:0] i_warn_wdata = 4'h0;
    logic [2:0] i_low_prio_stack_sel = 3'h0;
    logic [31:0] i_secure_stack_base [8];
    cirq_pkg::cirq_ctx_s i_ctx = '0, o_ctx;
    logic o_pipe_flush, o_take, o_ctx_busy, o_zero_working;
    logic o_restore_valid, o_a15_load;
    cirq_pkg::cirq_src_e o_take_src;
    logic [31:0] o_a15_value, o_irq_status_reg, o_main_status_reg;
    logic [cirq_pkg::PTR_W-1:0] o_rt_stack_depth_ptr, o_rt_stack_warn_level;
    logic [cirq_pkg::PTR_W-1:0] o_rt_stack_full_level;
    cirq_pkg::cirq_err_s o_err;
    int fails = 0, checked = 0, cycles = 0, w, k;
    logic [31:0] seed = 32'h0001_6a31;
    cirq_pkg::cirq_ctx_s saved [$];

    cirq_entry_unit u_cirq_entry_unit (.*);
    cirq_err_agg u_cirq_err_agg (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .i_sw_req(sw_req), .i_err(o_err),
        .o_critical_irq_low(i_critical_irq_low));

    // ========================================================
    // helpers
    initial forever #2.5 i_sys_clk = ~i_sys_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic warn_exp(input int d, input int lvl);
        return d >= lvl;
    endfunction : warn_exp
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : tick
    task automatic pulse_lp_enable();
        @(posedge i_sys_clk);
        i_lp_enable_set <= 1'b1;
        @(posedge i_sys_clk);
        i_lp_enable_set <= 1'b0;
    endtask : pulse_lp_enable
    task automatic do_reset();
        @(posedge i_sys_clk);
        i_reset <= 1'b1;
        saved.delete();
        tick(4);
        i_reset <= 1'b0;
        tick(3);
        #1;
        chk(o_main_status_reg, cirq_pkg::MAIN_STATUS_RESET);
        chk(o_irq_status_reg, cirq_pkg::ZERO_WORD);
        chk(o_pipe_flush, 1'b0);
        chk(o_rt_stack_depth_ptr, 4'h0);
        chk(o_rt_stack_warn_level, cirq_pkg::WARN_RESET);
        chk(o_rt_stack_full_level, cirq_pkg::STACK_DEPTH);
        $display("reset test done");
    endtask : do_reset
    task automatic no_take(input int n);
        repeat (n) begin
            @(posedge i_sys_clk);
            #1;
            chk(o_take, 1'b0);
        end
    endtask : no_take
    // req bit 0 critical, bit 1 real-time, bit 2 low-priority
    task automatic enter(input logic [2:0] req, input logic [1:0] src,
                         input int pkt);
        int n;
        cirq_pkg::cirq_ctx_s c;
        c = {rnd(), rnd(), rnd(), rnd()};
        @(posedge i_sys_clk);
        i_ctx <= c;
        sw_req <= req[0];
        i_realtime_irq <= req[1];
        i_low_prio_irq <= req[2];
        @(posedge i_sys_clk);
        sw_req <= 1'b0;
        n = 0;
        do begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end while (o_take !== 1'b1 && n < 30);
        chk(o_take_src, src);
        if (src != cirq_pkg::CIRQ_SRC_LP) saved.push_back(c);
        @(posedge i_sys_clk);
        i_realtime_irq <= 1'b0;
        i_low_prio_irq <= 1'b0;
        if (pkt != 0) begin
            tick(8);
            i_first_packet_valid <= 1'b1;
            i_handler_entry_op_a <= (pkt == 1);
            i_handler_entry_op_b <= 1'b1;
            @(posedge i_sys_clk);
            i_first_packet_valid <= 1'b0;
            tick(3);
            #1;
            if (pkt == 1) chk(o_a15_value, i_secure_stack_base[0]);
            else chk(o_err.entry_fault, 1'b1);
        end
    endtask : enter
    task automatic ret();
        int n;
        @(posedge i_sys_clk);
        i_realtime_return_op <= 1'b1;
        @(posedge i_sys_clk);
        i_realtime_return_op <= 1'b0;
        n = 0;
        do begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end while (o_restore_valid !== 1'b1 && n < 12);
        chk(o_ctx, saved.pop_back());
    endtask : ret

    // ========================================================
    // main sequence
    initial begin
        foreach (i_secure_stack_base[i]) i_secure_stack_base[i] = rnd();
        do_reset();
        w = 3 + rnd() % 4;
        @(posedge i_sys_clk);
        i_warn_we <= 1'b1;
        i_warn_wdata <= w[3:0];
        @(posedge i_sys_clk);
        i_warn_we <= 1'b0;
        tick(3);
        #1;
        chk(o_rt_stack_warn_level, w[3:0]);
        i_low_prio_stack_sel <= 3'h1;
        pulse_lp_enable();
        i_low_prio_irq <= 1'b1;
        no_take(20);
        i_low_prio_irq <= 1'b0;
        tick(3);
        i_low_prio_stack_sel <= 3'h0;
        enter(3'b100, cirq_pkg::CIRQ_SRC_LP, 0);
        tick(3);
        #1;
        chk(o_main_status_reg[cirq_pkg::LP_ENABLE_BIT], 1'b0);
        $display("low-priority test done");
        for (k = 1; k <= 7; k++) begin
            if (k == 3) pulse_lp_enable();
            i_uninterruptible_section_op <= (k == 5);
            enter(k == 5 ? 3'b111 : k == 3 ? 3'b110 : 3'b010,
                k == 5 ? cirq_pkg::CIRQ_SRC_CRIT : cirq_pkg::CIRQ_SRC_RT, 1);
            i_uninterruptible_section_op <= 1'b0;
            tick(2);
            #1;
            chk(o_rt_stack_depth_ptr, k);
            chk(o_err.stack_warn, warn_exp(k, w));
        end
        i_realtime_irq <= 1'b1;
        no_take(20);
        i_realtime_irq <= 1'b0;
        ret();
        ret();
        tick(2);
        #1;
        chk(o_rt_stack_depth_ptr, 4'h5);
        enter(3'b010, cirq_pkg::CIRQ_SRC_RT, 1);
        enter(3'b010, cirq_pkg::CIRQ_SRC_RT, 1);
        enter(3'b001, cirq_pkg::CIRQ_SRC_CRIT, 0);
        tick(12);
        #1;
        chk(o_err.stack_full, 1'b1);
        $display("nesting test done");
        do_reset();
        enter(3'b010, cirq_pkg::CIRQ_SRC_RT, 2);
        $display("entry packet test done");
        @(posedge i_sys_clk);
        i_cpu_reset_low <= 1'b0;
        tick(5);
        #1;
        chk(o_pipe_flush, 1'b1);
        @(posedge i_sys_clk);
        i_cpu_reset_low <= 1'b1;
        tick(6);
        #1;
        chk(o_err.entry_fault, 1'b0);
        chk(o_rt_stack_depth_ptr, 4'h0);
        $display("cpu reset test done");
        report_and_stop();
    end
endmodule : tb_top
